// file: inc/vmsr_pkg.sv
// Package with register offsets, field positions and carrier types of the legacy register bank.
package vmsr_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [15:0] misc_output_wr_addr = 16'h03c2;
  localparam logic [15:0] misc_output_rd_addr = 16'h03cc;
  localparam logic [15:0] seq_index_addr      = 16'h03c4;
  localparam logic [15:0] seq_data_addr       = 16'h03c5;
  localparam logic [15:0] mono_io_base        = 16'h03b0;
  localparam logic [15:0] colour_io_base      = 16'h03d0;
  localparam logic [15:0] io_group_mask       = 16'hfff0;

  // ****************************************************************
  // Sequencer indices
  // ****************************************************************
  localparam logic [2:0] idx_legacy_reset = 3'h0;
  localparam logic [2:0] idx_clocking     = 3'h1;
  localparam logic [2:0] idx_plane_mask   = 3'h2;
  localparam logic [2:0] idx_counter_hold = 3'h7;

  // ****************************************************************
  // Reset values and read masks
  // ****************************************************************
  localparam logic [7:0] reg_reset         = 8'h00;
  localparam logic [7:0] misc_rd_mask      = 8'hef;
  localparam logic [7:0] index_rd_mask     = 8'h07;
  localparam logic [7:0] legacy_rd_mask    = 8'h03;
  localparam logic [7:0] clocking_rd_mask  = 8'h3d;
  localparam logic [7:0] plane_rd_mask     = 8'h0f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int misc_vsync_neg_bit  = 7;
  localparam int misc_hsync_neg_bit  = 6;
  localparam int misc_page_low_bit   = 5;
  localparam int misc_clk_sel_hi     = 3;
  localparam int misc_clk_sel_lo     = 2;
  localparam int misc_aperture_bit   = 1;
  localparam int misc_colour_io_bit  = 0;
  localparam int clk_screen_off_bit  = 5;
  localparam int clk_shift4_bit      = 4;
  localparam int clk_dot_div_bit     = 3;
  localparam int clk_shift_load_bit  = 2;
  localparam int clk_eight_dot_bit   = 0;

  // ****************************************************************
  // Encodings and timing figures
  // ****************************************************************
  localparam logic [1:0] dot_clock_first  = 2'h0;
  localparam logic [1:0] dot_clock_second = 2'h1;
  localparam logic [4:0] char_width_nine  = 5'h09;
  localparam logic [4:0] char_width_eight = 5'h08;
  localparam logic [2:0] load_every_one   = 3'h1;
  localparam logic [2:0] load_every_two   = 3'h2;
  localparam logic [2:0] load_every_four  = 3'h4;
  localparam logic [15:0] aperture_lo_page = 16'h000a;
  localparam logic [15:0] aperture_hi_page = 16'h000b;

  typedef enum logic [1:0] {
    vmsr_lines_200,
    vmsr_lines_350,
    vmsr_lines_400,
    vmsr_lines_480
  } vmsr_lines_type;

  // Host access as it arrives on the bank's port.
  typedef struct packed {
    logic        io_wr;
    logic        io_rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vmsr_host_type;

  // Decoded display controls handed to the display engine.
  typedef struct packed {
    logic           vsync_neg;
    logic           hsync_neg;
    vmsr_lines_type lines;
    logic           page_low;
    logic [1:0]     dot_clk_sel;
    logic           aperture_en;
    logic           colour_io;
    logic           screen_off;
    logic [2:0]     load_interval;
    logic           dot_div2;
    logic [4:0]     char_width;
    logic [3:0]     plane_we;
  } vmsr_ctrl_type;

endpackage : vmsr_pkg

// file: core/vmsr_seq_decode.sv
// Decoder that turns clocking mode fields and the force-eight-dot input into display timing controls.
`timescale 1ns/1ns
module vmsr_seq_decode (
  input  wire logic [7:0] clocking_mode,
  input  wire logic       force_eight_dot,
  output logic      [2:0] load_interval,
  output logic            dot_div2,
  output logic      [4:0] char_width
);

  wire logic shift4     = clocking_mode[vmsr_pkg::clk_shift4_bit];
  wire logic shift_load = clocking_mode[vmsr_pkg::clk_shift_load_bit];
  wire logic eight_dot  = clocking_mode[vmsr_pkg::clk_eight_dot_bit] | force_eight_dot;
  wire logic [4:0] base_width = eight_dot ? vmsr_pkg::char_width_eight
                                          : vmsr_pkg::char_width_nine;

  assign load_interval = shift4 ? vmsr_pkg::load_every_four :
                         (shift_load ? vmsr_pkg::load_every_two : vmsr_pkg::load_every_one);
  assign dot_div2      = clocking_mode[vmsr_pkg::clk_dot_div_bit];
  assign char_width    = dot_div2 ? {base_width[3:0], 1'b0} : base_width;

endmodule : vmsr_seq_decode

// file: core/vmsr_regs.sv
// Miscellaneous output and sequencer register bank of the legacy display controller.
// Contract
// (R1) Misc bit 7 picks vertical sync polarity; 0 positive, 1 negative.
// (R2) Misc bit 6 picks horizontal sync polarity; 0 positive, 1 negative.
// (R3) Polarity pair encodes 200, 350, 400 or 480 active lines.
// (R4) Misc bit 5 picks upper (0) or lower (1) 64 KB page in odd/even.
// (R5) Misc bits 3:2 select dot clock; 00 first, 01 second, others unused.
// (R6) Misc bit 1 gates host access to legacy memory aperture.
// (R7) Aperture bit never blocks linear frame buffer accesses elsewhere.
// (R8) Misc bit 0 picks monochrome or colour I/O base for CRT group.
// (R9) Both monochrome and colour I/O ranges are claimed regardless.
// (R10) Misc written at 3C2h, read at 3CCh, resets 00h, bit 4 zero.
// (R11) Sequencer registers reached through index port 3C4h and data port 3C5h.
// (R12) Index register holds 3-bit index; upper bits read zero; resets 00h.
// (R13) Sequencer index 0 performs no reset; only bits 1:0 stored.
// (R14) Clocking bit 5 blanks video, stops fetches, keeps sync running; here it blanks video only while legacy_enable is high.
// (R15) Software sets screen-off before disabling legacy engine.
// (R16) Clocking bit 4 loads shift registers every fourth character clock.
// (R17) Clocking bit 3 halves pixel clock, doubling horizontal periods.
// (R18) Clocking bit 2 picks load every one or two clocks when bit 4 clear.
// (R19) Clocking bit 0 gives 8 or 9 dot characters, doubled when dividing.
// (R20) Separate force control overrides width bit to 8-dot characters.
// (R21) Plane mask bits 3:0 gate host writes per plane in all modes.
// (R22) Index 7 writes never hold or restart the character counter.
// (R23) Data port targets indexed register; unused bits read zero.
`timescale 1ns/1ns
module vmsr_regs (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire vmsr_pkg::vmsr_host_type host,
  output logic                   [7:0] rdata,
  output logic                         rd_hit,
  input  wire logic                    mem_req,
  input  wire logic                    mem_wr,
  input  wire logic             [19:0] mem_addr,
  input  wire logic              [3:0] mem_plane_sel,
  output logic                         mem_grant,
  output logic                   [3:0] mem_plane_we,
  input  wire logic                    force_eight_dot,
  input  wire logic                    legacy_enable,
  input  wire logic                    blank_in,
  output logic                         video_blank,
  output logic                         fetch_enable,
  output logic                         crt_group_hit,
  output vmsr_pkg::vmsr_ctrl_type      ctrl
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] misc_output_register;
  logic [2:0] seq_index_pointer;
  logic [1:0] seq_legacy_reset;
  logic [7:0] clocking_mode_ctrl;
  logic [3:0] plane_write_mask;
  logic [7:0] horiz_char_counter_hold;
  logic [7:0] next_rdata;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic misc_wr   = host.io_wr && host.addr == vmsr_pkg::misc_output_wr_addr; // R10
  wire logic misc_rd   = host.io_rd && host.addr == vmsr_pkg::misc_output_rd_addr; // R10
  wire logic index_wr  = host.io_wr && host.addr == vmsr_pkg::seq_index_addr; // R11
  wire logic index_rd  = host.io_rd && host.addr == vmsr_pkg::seq_index_addr; // R11
  wire logic data_wr   = host.io_wr && host.addr == vmsr_pkg::seq_data_addr; // R11
  wire logic data_rd   = host.io_rd && host.addr == vmsr_pkg::seq_data_addr; // R11
  wire logic wr_legacy = data_wr && seq_index_pointer == vmsr_pkg::idx_legacy_reset; // R23
  wire logic wr_clock  = data_wr && seq_index_pointer == vmsr_pkg::idx_clocking; // R23
  wire logic wr_plane  = data_wr && seq_index_pointer == vmsr_pkg::idx_plane_mask; // R23
  wire logic wr_hold   = data_wr && seq_index_pointer == vmsr_pkg::idx_counter_hold; // R22

  // Both I/O groups are claimed so software that still pokes the other base keeps working.
  wire logic mono_hit   = (host.addr & vmsr_pkg::io_group_mask) == vmsr_pkg::mono_io_base;
  wire logic colour_hit = (host.addr & vmsr_pkg::io_group_mask) == vmsr_pkg::colour_io_base;
  assign crt_group_hit  = (host.io_wr | host.io_rd) & (mono_hit | colour_hit); // R9

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      misc_output_register <= vmsr_pkg::reg_reset;
    end else if (misc_wr) begin
      misc_output_register <= host.wdata & vmsr_pkg::misc_rd_mask; // R10
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_index_pointer <= vmsr_pkg::reg_reset[2:0];
    end else if (index_wr) begin
      seq_index_pointer <= host.wdata[2:0]; // R12
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_legacy_reset        <= vmsr_pkg::reg_reset[1:0];
      clocking_mode_ctrl      <= vmsr_pkg::reg_reset;
      plane_write_mask        <= vmsr_pkg::reg_reset[3:0];
      horiz_char_counter_hold <= vmsr_pkg::reg_reset;
    end else begin
      if (wr_legacy) begin
        seq_legacy_reset <= host.wdata[1:0]; // R13
      end
      if (wr_clock) begin
        clocking_mode_ctrl <= host.wdata & vmsr_pkg::clocking_rd_mask;
      end
      if (wr_plane) begin
        plane_write_mask <= host.wdata[3:0]; // R21
      end
      // Kept only as a scratch value; it drives no counter hold or restart.
      if (wr_hold) begin
        horiz_char_counter_hold <= host.wdata; // R22
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire logic [7:0] seq_sel_data =
    (seq_index_pointer == vmsr_pkg::idx_legacy_reset) ? {6'h00, seq_legacy_reset} :
    (seq_index_pointer == vmsr_pkg::idx_clocking)     ? clocking_mode_ctrl :
    (seq_index_pointer == vmsr_pkg::idx_plane_mask)   ? {4'h0, plane_write_mask} :
    (seq_index_pointer == vmsr_pkg::idx_counter_hold) ? horiz_char_counter_hold :
                                                        8'h00; // R23

  assign next_rdata = misc_rd  ? misc_output_register :
                      index_rd ? {5'h00, seq_index_pointer} : // R12
                      data_rd  ? seq_sel_data : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata  <= vmsr_pkg::reg_reset;
      rd_hit <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rd_hit <= misc_rd | index_rd | data_rd;
    end
  end

  // ****************************************************************
  // Memory aperture and plane gating
  // ****************************************************************
  wire logic [15:0] mem_page = {12'h000, mem_addr[19:16]};
  wire logic in_aperture = mem_page == vmsr_pkg::aperture_lo_page ||
                           mem_page == vmsr_pkg::aperture_hi_page;
  wire logic aperture_en = misc_output_register[vmsr_pkg::misc_aperture_bit];

  // Outside the legacy window the aperture bit is not consulted at all.
  assign mem_grant    = mem_req & (~in_aperture | aperture_en); // R6 R7
  assign mem_plane_we = (mem_grant & mem_wr) ? (mem_plane_sel & plane_write_mask) : 4'h0; // R21

  // ****************************************************************
  // Display controls
  // ****************************************************************
  wire logic screen_off = clocking_mode_ctrl[vmsr_pkg::clk_screen_off_bit] & legacy_enable;
  assign video_blank  = blank_in | screen_off; // R14
  assign fetch_enable = legacy_enable & ~screen_off; // R14 R15

  wire logic vneg = misc_output_register[vmsr_pkg::misc_vsync_neg_bit];
  wire logic hneg = misc_output_register[vmsr_pkg::misc_hsync_neg_bit];
  wire vmsr_pkg::vmsr_lines_type lines_code = vmsr_pkg::vmsr_lines_type'({hneg, vneg}); // R3

  logic [2:0] load_interval;
  logic       dot_div2;
  logic [4:0] char_width;

  vmsr_seq_decode u_decode (
    .clocking_mode   (clocking_mode_ctrl),
    .force_eight_dot (force_eight_dot),
    .load_interval   (load_interval),
    .dot_div2        (dot_div2),
    .char_width      (char_width)
  );

  assign ctrl.vsync_neg     = vneg; // R1
  assign ctrl.hsync_neg     = hneg; // R2
  assign ctrl.lines         = lines_code;
  assign ctrl.page_low      = misc_output_register[vmsr_pkg::misc_page_low_bit]; // R4
  assign ctrl.dot_clk_sel   = misc_output_register[vmsr_pkg::misc_clk_sel_hi:
                                                   vmsr_pkg::misc_clk_sel_lo]; // R5
  assign ctrl.aperture_en   = aperture_en;
  assign ctrl.colour_io     = misc_output_register[vmsr_pkg::misc_colour_io_bit]; // R8
  assign ctrl.screen_off    = screen_off;
  assign ctrl.load_interval = load_interval; // R16 R18
  assign ctrl.dot_div2      = dot_div2; // R17
  assign ctrl.char_width    = char_width; // R19 R20
  assign ctrl.plane_we      = plane_write_mask;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_misc_write_read: assert property (@(posedge clk) disable iff (!nrst) // R10
    misc_wr ##1 (misc_rd && !misc_wr) |=> rdata == ($past(host.wdata, 2) & 8'hef))
    else $error("misc output readback mismatch");
  chk_index_upper_zero: assert property (@(posedge clk) disable iff (!nrst) // R12
    index_rd |=> rdata[7:3] == 5'h00)
    else $error("index upper bits not zero");
  chk_legacy_upper_zero: assert property (@(posedge clk) disable iff (!nrst) // R13
    data_rd && seq_index_pointer == 3'h0 |=> rdata[7:2] == 6'h00)
    else $error("legacy reset upper bits not zero");
  chk_aperture_block: assert property (@(posedge clk) disable iff (!nrst) // R6
    mem_req && in_aperture && !aperture_en |-> !mem_grant)
    else $error("aperture access not blocked");
  chk_linear_pass: assert property (@(posedge clk) disable iff (!nrst) // R7
    mem_req && !in_aperture |-> mem_grant)
    else $error("linear access blocked");
  chk_plane_gate: assert property (@(posedge clk) disable iff (!nrst) // R21
    wr_plane ##1 (mem_req && mem_wr && !wr_plane) |-> (mem_plane_we & ~$past(host.wdata[3:0])) == 4'h0)
    else $error("masked plane written");
  chk_screen_blank: assert property (@(posedge clk) disable iff (!nrst) // R14
    wr_clock && host.wdata[5] ##1 legacy_enable |-> video_blank && !fetch_enable)
    else $error("screen off not blanking");
  chk_shift4_load: assert property (@(posedge clk) disable iff (!nrst) // R16
    wr_clock && host.wdata[4] |=> load_interval == 3'h4)
    else $error("shift four interval wrong");
  chk_width_div: assert property (@(posedge clk) disable iff (!nrst) // R19
    wr_clock && host.wdata[3] && !host.wdata[0] ##1 !force_eight_dot |-> char_width == 5'h12)
    else $error("doubled nine dot width wrong");
  chk_force_eight: assert property (@(posedge clk) disable iff (!nrst) // R20
    force_eight_dot && !dot_div2 |-> char_width == 5'h08)
    else $error("forced eight dot not applied");
  chk_lines_code: assert property (@(posedge clk) disable iff (!nrst) // R3
    misc_wr && host.wdata[7:6] == 2'h3 |=> ctrl.lines == vmsr_pkg::vmsr_lines_480)
    else $error("480 line code wrong");
  chk_misc_gap_read: assert property (@(posedge clk) disable iff (!nrst) // R10
    misc_wr ##1 !misc_wr ##1 (misc_rd && !misc_wr) |=>
      rdata == ($past(host.wdata, 3) & vmsr_pkg::misc_rd_mask))
    else $error("misc output readback after gap mismatch");
  chk_unmapped_read: assert property (@(posedge clk) disable iff (!nrst) // R23
    host.io_rd && !misc_rd && !index_rd && !data_rd |=> rdata == 8'h00 && !rd_hit)
    else $error("unmapped read returned data");
  chk_mono_claimed: assert property (@(posedge clk) disable iff (!nrst) // R9
    host.io_wr && mono_hit && ctrl.colour_io |-> crt_group_hit)
    else $error("monochrome range dropped in colour emulation");
  chk_colour_claimed: assert property (@(posedge clk) disable iff (!nrst) // R9
    host.io_wr && colour_hit && !ctrl.colour_io |-> crt_group_hit)
    else $error("colour range dropped in monochrome emulation");
  chk_dot_clock_sel: assert property (@(posedge clk) disable iff (!nrst) // R5
    misc_wr && host.wdata[3:2] == 2'h1 |=> ctrl.dot_clk_sel == vmsr_pkg::dot_clock_second)
    else $error("second dot clock not selected");
  chk_aperture_grant: assert property (@(posedge clk) disable iff (!nrst) // R6
    mem_req && in_aperture && aperture_en |-> mem_grant)
    else $error("enabled aperture access blocked");
  chk_load_two: assert property (@(posedge clk) disable iff (!nrst) // R18
    wr_clock && host.wdata[2] && !host.wdata[4] |=> load_interval == vmsr_pkg::load_every_two)
    else $error("every other load interval wrong");
  chk_dot_divide: assert property (@(posedge clk) disable iff (!nrst) // R17
    wr_clock && host.wdata[3] |=> dot_div2)
    else $error("dot clock divide not applied");

endmodule : vmsr_regs

// file: tb/vmsr_host_model.sv
// Host model that issues byte-wide register accesses to the bank.
`timescale 1ns/1ns
module vmsr_host_model (
  input  wire logic               clk,
  output vmsr_pkg::vmsr_host_type host,
  input  wire logic         [7:0] rdata,
  input  wire logic               rd_hit
);
  initial begin
    host = '0;
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  // Idle address and data lines show the inverse of the last value, so a
  // stale bus never passes for a held request.
  task automatic idle();
    host.io_wr = 1'b0;
    host.io_rd = 1'b0;
    host.addr  = ~host.addr;
    host.wdata = ~host.wdata;
  endtask : idle

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    host.addr  = a;
    host.wdata = d;
    host.io_wr = 1'b1;
    @(posedge clk);
    #1;
    idle();
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic h);
    @(posedge clk);
    #1;
    host.addr  = a;
    host.io_rd = 1'b1;
    @(posedge clk);
    #1;
    d = rdata;
    h = rd_hit;
    idle();
  endtask : rd

  // The index always goes to its port before the data port is touched.
  task automatic seq_wr(input logic [2:0] i, input logic [7:0] d);
    wr(vmsr_pkg::seq_index_addr, {5'h00, i});
    wr(vmsr_pkg::seq_data_addr, d);
  endtask : seq_wr
endmodule : vmsr_host_model

// file: tb/test_vmsr_regs.sv
// Self-checking testbench of the legacy register bank.
`timescale 1ns/1ns
module test_vmsr_regs;
  logic                    clk, nrst, mem_req, mem_wr, rd_hit, mem_grant;
  logic                    force_eight_dot, legacy_enable, blank_in;
  logic                    video_blank, fetch_enable, crt_group_hit, crt_seen;
  logic              [7:0] rdata;
  logic             [19:0] mem_addr;
  logic              [3:0] mem_plane_sel, mem_plane_we;
  vmsr_pkg::vmsr_host_type host;
  vmsr_pkg::vmsr_ctrl_type ctrl;
  int                      n_mismatch, n_tests, cycles;
  logic              [7:0] cm_val [7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h08, 8'h09, 8'h01};
  logic              [2:0] li_exp [7] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h1};
  logic              [4:0] cw_exp [7] = '{5'h09, 5'h09, 5'h09, 5'h09, 5'h12, 5'h10, 5'h08};

  vmsr_regs vmsr_regs_i (.clk(clk), .nrst(nrst), .host(host), .rdata(rdata),
    .rd_hit(rd_hit), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_plane_sel(mem_plane_sel), .mem_grant(mem_grant), .mem_plane_we(mem_plane_we),
    .force_eight_dot(force_eight_dot), .legacy_enable(legacy_enable),
    .blank_in(blank_in), .video_blank(video_blank), .fetch_enable(fetch_enable),
    .crt_group_hit(crt_group_hit), .ctrl(ctrl));
  vmsr_host_model vmsr_host_model_i (.clk(clk), .host(host), .rdata(rdata),
    .rd_hit(rd_hit));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input logic eh);
    logic [7:0] d;
    logic       h;
    vmsr_host_model_i.rd(a, d, h);
    chk(d, e);
    chk(h, eh);
  endtask : rchk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // A hang is cut short well beyond the roughly 130 cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (crt_group_hit) crt_seen <= 1'b1;
    if (cycles == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {mem_req, mem_wr, force_eight_dot, blank_in, crt_seen} = '0;
    {mem_addr, mem_plane_sel, n_mismatch, n_tests, cycles} = '0;
    legacy_enable = 1'b1;
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    rchk(vmsr_pkg::misc_output_rd_addr, 8'h00, 1'b1);
    rchk(vmsr_pkg::seq_index_addr, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++) begin
      vmsr_host_model_i.seq_wr(i[2:0], 8'hff);
      chk(ctrl.plane_we, i == 2 ? 4'hf : 4'h0);
      rchk(vmsr_pkg::seq_data_addr, i == 0 ? 8'h03 : i == 1 ? 8'h3d : 8'h0f, 1'b1);
    end
    vmsr_host_model_i.seq_wr(3'h7, 8'h5a);
    rchk(vmsr_pkg::seq_data_addr, 8'h5a, 1'b1);
    vmsr_host_model_i.seq_wr(3'h3, 8'hff);
    rchk(vmsr_pkg::seq_data_addr, 8'h00, 1'b1);
    vmsr_host_model_i.wr(vmsr_pkg::seq_index_addr, 8'hff);
    rchk(vmsr_pkg::seq_index_addr, 8'h07, 1'b1);
    vmsr_host_model_i.wr(vmsr_pkg::misc_output_wr_addr, 8'hff);
    rchk(vmsr_pkg::misc_output_rd_addr, 8'hef, 1'b1);
    rchk(vmsr_pkg::misc_output_wr_addr, 8'h00, 1'b0);
    rchk(16'h03c0, 8'h00, 1'b0);
    chk({ctrl.page_low, ctrl.dot_clk_sel, ctrl.aperture_en, ctrl.colour_io}, 5'h1f);
    for (int i = 0; i < 4; i++) begin
      vmsr_host_model_i.wr(vmsr_pkg::misc_output_wr_addr, {i[0], i[1], 6'h04});
      chk({ctrl.vsync_neg, ctrl.hsync_neg, ctrl.lines}, {i[0], i[1], i[1:0]});
      chk(ctrl.dot_clk_sel, 2'h1);
    end
    // Both emulation ranges must be claimed whichever base is selected.
    for (int i = 0; i < 4; i++) begin
      vmsr_host_model_i.wr(vmsr_pkg::misc_output_wr_addr, {7'h00, i[1]});
      crt_seen = 1'b0;
      vmsr_host_model_i.wr(i[0] ? 16'h03d4 : 16'h03b4, 8'h00);
      chk(crt_seen, 1'b1);
    end
    {mem_req, mem_wr, mem_plane_sel} = 6'h3f;
    vmsr_host_model_i.seq_wr(vmsr_pkg::idx_plane_mask, 8'h05);
    vmsr_host_model_i.wr(vmsr_pkg::misc_output_wr_addr, 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1 mem_addr = i == 0 ? 20'ha0000 : i == 1 ? 20'hbffff : 20'h10000;
      #1 chk(mem_grant, i == 2);
    end
    vmsr_host_model_i.wr(vmsr_pkg::misc_output_wr_addr, 8'h02);
    mem_addr = 20'ha1234;
    #1 chk({mem_grant, mem_plane_we}, 5'h15);
    for (int i = 0; i < 7; i++) begin
      vmsr_host_model_i.seq_wr(vmsr_pkg::idx_clocking, cm_val[i]);
      chk({ctrl.load_interval, ctrl.dot_div2, ctrl.char_width}, {li_exp[i], i[2:0] > 3 && i < 6, cw_exp[i]});
    end
    vmsr_host_model_i.seq_wr(vmsr_pkg::idx_clocking, 8'h00);
    force_eight_dot = 1'b1;
    #1 chk(ctrl.char_width, 5'h08);
    // Screen-off goes first, then the legacy engine is switched off.
    vmsr_host_model_i.seq_wr(vmsr_pkg::idx_clocking, 8'h20);
    chk({ctrl.screen_off, video_blank, fetch_enable}, 3'h6);
    legacy_enable = 1'b0;
    #1 chk({video_blank, fetch_enable}, 2'h0);
    @(posedge clk);
    #1 blank_in = 1'b1;
    #1 chk(video_blank, 1'b1);
    // A second reset in mid-run must bring the clocking, plane mask and misc output registers back to their defaults.
    @(posedge clk);
    #1 nrst = 1'b0;
    blank_in = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    chk({ctrl.screen_off, ctrl.plane_we, ctrl.load_interval}, 8'h01);
    rchk(vmsr_pkg::misc_output_rd_addr, 8'h00, 1'b1);
    end_sim();
  end
endmodule : test_vmsr_regs
